// ==== oac_map.svh ====
// constants for the octal converter serial control block
// Summary of operation
// - conversion start rising edge puts all holds into hold and starts converting
// - conversion start works whatever the chip select state
// - all eight channels sampled together, each digitised differentially
// - busy rises at each conversion start, stays high until it ends
// - while power-down is high the device sleeps and ignores conversion requests
// - power-down during a conversion takes effect after that conversion ends
// - two power-down pulses with no conversion between cause a global reset
// - mode pin high selects differential mode, low selects CMOS mode
// - CMOS mode: result words shift out on eight lanes per rising clock
// - CMOS mode: serial config input sampled on rising shift clock edges
// - CMOS mode: returned clock toggles per rising edge, half rate, data aligned
// - returned clock forced low when busy falls
// - chip select low enables the bus; high floats outputs and gates clock
// - differential mode: config input sampled on both shift clock edges
// - differential mode: one lane, both edges, channel 0 first
// - differential mode: returned clock copies the incoming shift clock
// - differential mode: CMOS data lanes and config pin stay floating
// - differential terminations on only while chip select is low
// - eight 3-bit span codes form the 24-bit configuration word
// - codes with bit1 set give two's complement, others binary, 000 zeros
`ifndef OAC_MAP_SVH
`define OAC_MAP_SVH
`define OAC_NCH 8
`define OAC_RES_W 18
`define OAC_WORD_W 24
`define OAC_SPAN_W 3
`define OAC_FRAME_W 192
`define OAC_FRAME_BITS 8'hC0
`define OAC_CFG_BITS 5'h18
`define OAC_SPAN_RESET 24'hFFFFFF
`define OAC_SPAN_OFF 3'h0
`define OAC_PINS_RESET 7'h08
`define OAC_TWOS_BIT 1
`define OAC_CONV_TIME_NS 3000
`define OAC_MCLK_MHZ 50
`define OAC_CONV_CYC ((`OAC_CONV_TIME_NS * `OAC_MCLK_MHZ + 999) / 1000)
`endif

// ==== oac_pkg.sv ====
// types shared by the converter serial control block
package oac_pkg;
    // pins sampled from outside the clock domain
    typedef struct packed {
        logic conv;
        logic pd;
        logic lvds;
        logic cs_n;
        logic sck;
        logic sdi_cmos;
        logic sdi_diff;
    } oac_pins_type;
    // one channel's word as it leaves the device
    typedef struct packed {
        logic [17:0] result;
        logic [2:0] chan;
        logic [2:0] span;
    } oac_word_type;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DOWN} oac_state_type;
endpackage

// ==== oac_result_mem.sv ====
// result store: eight channel words, registered read of all of them
`timescale 1ns/1ps
`include "oac_map.svh"
module oac_result_mem (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // write side
    input wire logic i_clear,
    input wire logic i_wr_en,
    input wire logic [`OAC_FRAME_W-1:0] i_wr_words,
    // read side
    output logic [`OAC_FRAME_W-1:0] o_rd_words
);
    logic [`OAC_FRAME_W-1:0] mem_reg;

    // whole frame written at once so all channels stay from one sample
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mem_reg <= '0;
            o_rd_words <= '0;
        end
        else
        begin
            mem_reg <= i_clear ? '0 : (i_wr_en ? i_wr_words : mem_reg);
            o_rd_words <= mem_reg;
        end
    end
endmodule

// ==== oac_adc_serial_control.sv ====
// conversion control and serial port of the octal converter
`timescale 1ns/1ps
`include "oac_map.svh"
module oac_adc_serial_control (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // conversion control pins
    input wire logic i_conversion_start_pin,
    input wire logic i_power_down_input,
    input wire logic i_io_mode_lvds,
    // serial bus pins
    input wire logic i_cs_n,
    input wire logic i_shift_clock_in,
    input wire logic i_serial_config_in,
    input wire logic i_diff_config_in,
    // converter core results, offset binary, channel 0 in low bits
    input wire logic [`OAC_NCH*`OAC_RES_W-1:0] i_core_result,
    // conversion status
    output logic o_busy,
    output logic o_hold,
    output logic o_powered_down,
    // CMOS data lanes
    output logic [`OAC_NCH-1:0] o_serial_data_out_lanes,
    output logic [`OAC_NCH-1:0] o_serial_data_out_lanes_oe,
    // differential data lane
    output logic o_diff_data_out_pair,
    output logic o_diff_data_out_pair_oe,
    // returned clock
    output logic o_returned_clock_out,
    output logic o_returned_clock_out_oe,
    // differential terminations
    output logic o_clk_term_en,
    output logic o_data_term_en
);
    oac_pkg::oac_pins_type pin_raw;
    oac_pkg::oac_pins_type s1_reg;
    oac_pkg::oac_pins_type s2_reg;
    oac_pkg::oac_pins_type s3_reg;
    oac_pkg::oac_pins_type flt_reg;
    oac_pkg::oac_pins_type flt_next;
    oac_pkg::oac_pins_type prev_reg;
    oac_pkg::oac_state_type state_reg;
    oac_pkg::oac_state_type state_next;
    logic [7:0] timer_reg;
    logic [7:0] timer_next;
    logic armed_reg;
    logic armed_next;
    logic gres_reg;
    logic gres_next;
    logic [23:0] cfg_sh_reg;
    logic [23:0] cfg_sh_next;
    logic [4:0] cfg_cnt_reg;
    logic [4:0] cfg_cnt_next;
    logic [23:0] pend_reg;
    logic [23:0] pend_next;
    logic [23:0] span_reg;
    logic [23:0] span_next;
    logic [7:0] out_cnt_reg;
    logic [7:0] out_cnt_next;
    logic rclk_next;
    logic [`OAC_NCH-1:0] lane_next;
    logic diff_next;
    logic [`OAC_FRAME_W-1:0] wr_words;
    logic [`OAC_FRAME_W-1:0] rd_words;

    // offset binary core code to output word
    function automatic oac_pkg::oac_word_type fmt_word(
        input logic [17:0] res,
        input logic [2:0] code,
        input logic [2:0] ch
    );
        oac_pkg::oac_word_type w;
        w.chan = ch;
        w.span = code;
        if (code == `OAC_SPAN_OFF)
            w.result = '0;
        else if (code[`OAC_TWOS_BIT])
            w.result = {~res[17], res[16:0]};
        else
            w.result = res;
        return w;
    endfunction

    // bit of the frame: word index, then MSB-first position in the word
    function automatic logic frame_bit(
        input logic [`OAC_FRAME_W-1:0] words,
        input logic [2:0] ch,
        input logic [7:0] cnt
    );
        logic [4:0] pos;
        logic [7:0] idx;
        pos = 5'(cnt % 8'(`OAC_WORD_W));
        idx = 8'(ch * `OAC_WORD_W + `OAC_WORD_W - 1 - pos);
        return words[idx];
    endfunction

    // word group the counter points at
    function automatic logic [2:0] group_of(input logic [7:0] cnt);
        return 3'(cnt / 8'(`OAC_WORD_W));
    endfunction

    // pins gathered for the synchroniser
    assign pin_raw.conv = i_conversion_start_pin;
    assign pin_raw.pd = i_power_down_input;
    assign pin_raw.lvds = i_io_mode_lvds;
    assign pin_raw.cs_n = i_cs_n;
    assign pin_raw.sck = i_shift_clock_in;
    assign pin_raw.sdi_cmos = i_serial_config_in;
    assign pin_raw.sdi_diff = i_diff_config_in;

    // a bit changes only once stages two and three agree, which filters a
    // metastable first stage at the cost of one more cycle of delay
    assign flt_next = oac_pkg::oac_pins_type'((s2_reg & s3_reg)
        | (flt_reg & (s2_reg ^ s3_reg)));

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        // select resets to its idle high level so no false select follows reset
        if (!i_rstn)
        begin
            s1_reg <= oac_pkg::oac_pins_type'(`OAC_PINS_RESET);
            s2_reg <= oac_pkg::oac_pins_type'(`OAC_PINS_RESET);
            s3_reg <= oac_pkg::oac_pins_type'(`OAC_PINS_RESET);
            flt_reg <= oac_pkg::oac_pins_type'(`OAC_PINS_RESET);
            prev_reg <= oac_pkg::oac_pins_type'(`OAC_PINS_RESET);
        end
        else
        begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= flt_next;
            prev_reg <= flt_reg;
        end
    end

    // edges and decoded levels
    wire conv_rise = flt_reg.conv & ~prev_reg.conv;
    wire pd_rise = flt_reg.pd & ~prev_reg.pd;
    wire sck_rise = flt_reg.sck & ~prev_reg.sck;
    wire sck_fall = ~flt_reg.sck & prev_reg.sck;
    wire lvds_mode = flt_reg.lvds;
    wire cs_act = ~flt_reg.cs_n;
    wire sdi_bit = lvds_mode ? flt_reg.sdi_diff : flt_reg.sdi_cmos;
    // chip select gates the clock; one edge in CMOS, both in LVDS
    wire shift_ev = cs_act & (lvds_mode ? (sck_rise | sck_fall) : sck_rise);
    wire conv_start = (state_reg == oac_pkg::ST_IDLE) & ~flt_reg.pd & conv_rise;
    wire conv_done = (state_reg == oac_pkg::ST_CONV) & (timer_reg == 8'h01);

    // conversion sequencer
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            oac_pkg::ST_IDLE:
            begin
                if (flt_reg.pd)
                    state_next = oac_pkg::ST_DOWN;
                else if (conv_rise)
                    state_next = oac_pkg::ST_CONV;
            end
            oac_pkg::ST_CONV:
            begin
                // a power-down here waits for the result
                if (conv_done)
                    state_next = flt_reg.pd ? oac_pkg::ST_DOWN : oac_pkg::ST_IDLE;
            end
            oac_pkg::ST_DOWN:
            begin
                // requests while asleep are dropped, not queued
                if (!flt_reg.pd)
                    state_next = oac_pkg::ST_IDLE;
            end
        endcase
    end

    // conversion timer
    assign timer_next = conv_start ? 8'(`OAC_CONV_CYC)
        : ((state_reg == oac_pkg::ST_CONV) ? timer_reg - 8'h01 : timer_reg);

    // second power-down pulse without a conversion between resets spans and stored results
    assign armed_next = gres_reg ? 1'b0
        : (conv_start ? 1'b0 : (pd_rise ? ~armed_reg : armed_reg));
    assign gres_next = pd_rise & armed_reg & ~conv_start;

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= oac_pkg::ST_IDLE;
            timer_reg <= '0;
            armed_reg <= 1'b0;
            gres_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            armed_reg <= armed_next;
            gres_reg <= gres_next;
        end
    end

    // span word shifter: MSB first, counting from select falling
    assign cfg_sh_next = (shift_ev & (cfg_cnt_reg < `OAC_CFG_BITS))
        ? {cfg_sh_reg[22:0], sdi_bit} : cfg_sh_reg;
    assign cfg_cnt_next = !cs_act ? 5'h00
        : ((shift_ev & (cfg_cnt_reg < `OAC_CFG_BITS)) ? cfg_cnt_reg + 5'h01 : cfg_cnt_reg);
    // a short word is dropped; only a full 24 bits replaces the pending span
    assign pend_next = gres_reg ? `OAC_SPAN_RESET
        : ((cfg_cnt_next == `OAC_CFG_BITS) & (cfg_cnt_reg != `OAC_CFG_BITS))
        ? cfg_sh_next : pend_reg;
    // new span takes effect with the next conversion
    assign span_next = gres_reg ? `OAC_SPAN_RESET : (conv_start ? pend_reg : span_reg);

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cfg_sh_reg <= '0;
            cfg_cnt_reg <= '0;
            pend_reg <= `OAC_SPAN_RESET;
            span_reg <= `OAC_SPAN_RESET;
        end
        else
        begin
            cfg_sh_reg <= cfg_sh_next;
            cfg_cnt_reg <= cfg_cnt_next;
            pend_reg <= pend_next;
            span_reg <= span_next;
        end
    end

    // every channel formatted from the same held sample
    always_comb
    begin
        wr_words = '0;
        for (int k = 0; k < `OAC_NCH; k++)
        begin
            wr_words[k*`OAC_WORD_W +: `OAC_WORD_W] = fmt_word(
                i_core_result[k*`OAC_RES_W +: `OAC_RES_W],
                span_reg[k*`OAC_SPAN_W +: `OAC_SPAN_W], 3'(k));
        end
    end

    oac_result_mem u_mem (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_clear(gres_reg),
        .i_wr_en(conv_done),
        .i_wr_words(wr_words),
        .o_rd_words(rd_words)
    );

    // output bit counter restarts with each select and each new result
    assign out_cnt_next = (!cs_act | conv_done) ? 8'h00
        : ((shift_ev & (out_cnt_reg < `OAC_FRAME_BITS)) ? out_cnt_reg + 8'h01 : out_cnt_reg);

    // lane k starts at channel k and wraps through the rest
    always_comb
    begin
        lane_next = '0;
        for (int k = 0; k < `OAC_NCH; k++)
        begin
            lane_next[k] = (out_cnt_next < `OAC_FRAME_BITS)
                & frame_bit(rd_words, 3'(k) + group_of(out_cnt_next), out_cnt_next);
        end
    end

    // single lane walks channel 0 to 7
    assign diff_next = (out_cnt_next < `OAC_FRAME_BITS)
        & frame_bit(rd_words, group_of(out_cnt_next), out_cnt_next);

    // CMOS toggles per rising edge, LVDS copies the clock; both low at busy fall
    assign rclk_next = conv_done ? 1'b0
        : (lvds_mode ? (cs_act & flt_reg.sck)
        : (shift_ev ? ~o_returned_clock_out : o_returned_clock_out));

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            out_cnt_reg <= '0;
            o_busy <= 1'b0;
            o_hold <= 1'b0;
            o_powered_down <= 1'b0;
        end
        else
        begin
            out_cnt_reg <= out_cnt_next;
            o_busy <= (state_next == oac_pkg::ST_CONV);
            o_hold <= (state_next == oac_pkg::ST_CONV);
            o_powered_down <= (state_next == oac_pkg::ST_DOWN);
        end
    end

    // pin drivers; enables follow select and mode so lanes float in LVDS
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_serial_data_out_lanes <= '0;
            o_serial_data_out_lanes_oe <= '0;
            o_diff_data_out_pair <= 1'b0;
            o_diff_data_out_pair_oe <= 1'b0;
            o_returned_clock_out <= 1'b0;
            o_returned_clock_out_oe <= 1'b0;
            o_clk_term_en <= 1'b0;
            o_data_term_en <= 1'b0;
        end
        else
        begin
            o_serial_data_out_lanes <= lane_next;
            o_serial_data_out_lanes_oe <= {`OAC_NCH{cs_act & ~lvds_mode}};
            o_diff_data_out_pair <= diff_next;
            o_diff_data_out_pair_oe <= cs_act & lvds_mode;
            o_returned_clock_out <= rclk_next;
            o_returned_clock_out_oe <= cs_act;
            o_clk_term_en <= cs_act & lvds_mode;
            o_data_term_en <= cs_act & lvds_mode;
        end
    end
endmodule

// ==== oac_adc_serial_control_props.sv ====
// concurrent checks on the pins of the converter serial control block
`timescale 1ns/1ps
module oac_adc_serial_control_props (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // bus select
    input wire logic i_cs_n,
    // status outputs
    input wire logic o_busy,
    input wire logic o_hold,
    input wire logic o_powered_down,
    // serial outputs
    input wire logic [7:0] o_serial_data_out_lanes_oe,
    input wire logic o_diff_data_out_pair_oe,
    input wire logic o_returned_clock_out,
    input wire logic o_returned_clock_out_oe,
    input wire logic o_clk_term_en,
    input wire logic o_data_term_en
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    logic [8:0] busy_cnt;
    // length of the current busy period, so the full count is checked exactly
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
            busy_cnt <= 9'h0;
        else
            busy_cnt <= o_busy ? busy_cnt + 9'h1 : 9'h0;
    end
    a_hold_tracks_busy: assert property (o_hold == o_busy)
        else $error("hold differs from busy");
    a_busy_full_length: assert property ($fell(o_busy) |-> busy_cnt == 9'h96)
        else $error("busy period has the wrong length");
    a_rc_low_end: assert property ($fell(o_busy) |-> !o_returned_clock_out)
        else $error("returned clock not low at busy fall");
    a_sleep_no_start: assert property (o_powered_down |-> !$rose(o_busy))
        else $error("conversion started while asleep");
    a_sleep_after_conv: assert property (o_busy |-> !o_powered_down)
        else $error("asleep during a conversion");
    a_one_mode_only: assert property (!(o_diff_data_out_pair_oe && |o_serial_data_out_lanes_oe))
        else $error("both lane kinds enabled");
    a_lanes_together: assert property (o_serial_data_out_lanes_oe inside {8'h00, 8'hFF})
        else $error("lane enables differ");
    a_terms_follow_oe: assert property (o_clk_term_en == o_diff_data_out_pair_oe
        && o_data_term_en == o_clk_term_en)
        else $error("termination enables wrong");
    a_idle_bus_float: assert property (i_cs_n [*8] |-> !o_returned_clock_out_oe
        && o_serial_data_out_lanes_oe == 8'h00 && !o_diff_data_out_pair_oe)
        else $error("outputs driven while deselected");
endmodule
bind oac_adc_serial_control oac_adc_serial_control_props oac_adc_serial_control_props_inst (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .o_busy(o_busy), .o_hold(o_hold),
    .o_powered_down(o_powered_down), .o_serial_data_out_lanes_oe(o_serial_data_out_lanes_oe),
    .o_diff_data_out_pair_oe(o_diff_data_out_pair_oe),
    .o_returned_clock_out(o_returned_clock_out),
    .o_returned_clock_out_oe(o_returned_clock_out_oe),
    .o_clk_term_en(o_clk_term_en), .o_data_term_en(o_data_term_en));

// ==== oac_host_model.sv ====
// serial host model: one select per call, clock still between frames
`timescale 1ns/1ps
module oac_host_model (
    // clock
    input wire logic i_mclk,
    // device side
    input wire logic i_data,
    input wire logic i_rc,
    // host pins
    output logic o_cs_n,
    output logic o_sck,
    output logic o_sdi,
    // captured bits, oldest highest
    output logic [47:0] o_cap
);
    logic rc_q;
    // config input idles high so every channel keeps span 7
    initial
    begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b1;
        o_cap = 48'h0;
        rc_q = 1'b0;
    end
    // double-rate capture on every returned clock change
    always @(negedge i_mclk)
    begin
        if (!o_cs_n && i_rc != rc_q)
            o_cap <= {o_cap[46:0], i_data};
        rc_q <= i_rc;
    end
    // 24 shift events, 160 ns apart in CMOS and 80 ns in LVDS, span word MSB first, data moved mid-half
    task automatic frame(input logic lvds, input logic [23:0] w);
        int k;
        k = 0;
        @(negedge i_mclk);
        o_cs_n = 1'b0;
        o_sdi = w[23];
        repeat (8) @(negedge i_mclk);
        o_cap = {o_cap[46:0], i_data};
        for (int h = 0; h < (lvds ? 24 : 48); h++)
        begin
            o_sck = ~o_sck;
            if (lvds || o_sck)
                k++;
            repeat (2) @(negedge i_mclk);
            o_sdi = (k < 24) ? w[23-k] : ~o_sdi;
            repeat (2) @(negedge i_mclk);
        end
        repeat (8) @(negedge i_mclk);
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
    endtask
endmodule

// ==== oac_adc_serial_control_tb_top.sv ====
// testbench: conversions, span words in both modes, power down and global reset
`timescale 1ns/1ps
`include "oac_map.svh"
module oac_adc_serial_control_tb_top;
    localparam logic [17:0] CORE0 = 18'h2A5C3;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic conv = 1'b0;
    logic pd = 1'b0;
    logic lvds = 1'b0;
    logic [`OAC_NCH*`OAC_RES_W-1:0] core = {`OAC_NCH{CORE0}};
    logic cs_n, sck, serial_config_in, busy, hold, pdn, dd, dd_oe, rc, rc_oe, cterm, dterm;
    logic [7:0] lanes, lanes_oe;
    logic [47:0] cap;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #10 mclk = ~mclk;
    oac_adc_serial_control oac_adc_serial_control_inst (
        .i_mclk(mclk), .i_rstn(rstn), .i_conversion_start_pin(conv),
        .i_power_down_input(pd), .i_io_mode_lvds(lvds), .i_cs_n(cs_n),
        .i_shift_clock_in(sck), .i_serial_config_in(serial_config_in), .i_diff_config_in(serial_config_in),
        .i_core_result(core), .o_busy(busy), .o_hold(hold), .o_powered_down(pdn),
        .o_serial_data_out_lanes(lanes), .o_serial_data_out_lanes_oe(lanes_oe),
        .o_diff_data_out_pair(dd), .o_diff_data_out_pair_oe(dd_oe),
        .o_returned_clock_out(rc), .o_returned_clock_out_oe(rc_oe),
        .o_clk_term_en(cterm), .o_data_term_en(dterm));
    oac_host_model oac_host_model_inst (
        .i_mclk(mclk), .i_data(lvds ? dd : lanes[0]), .i_rc(rc),
        .o_cs_n(cs_n), .o_sck(sck), .o_sdi(serial_config_in), .o_cap(cap));
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // channel 0 word: core is offset binary, bit1 of the code flips the msb
    function automatic logic [23:0] exp_word(input logic [2:0] c);
        logic [17:0] r;
        r = (c == 3'h0) ? 18'h0 : (c[1] ? CORE0 ^ 18'h20000 : CORE0);
        return {r, 3'h0, c};
    endfunction
    // one conversion; busy high cycles counted, power-down raised as soon as busy is seen high on request
    task automatic convert(input logic pd_mid, output logic [23:0] len);
        int w;
        w = 0;
        len = 24'h0;
        @(negedge mclk);
        conv = 1'b1;
        while (busy !== 1'b1 && w < 20)
        begin
            @(negedge mclk);
            w++;
        end
        pd = pd_mid;
        while (busy === 1'b1 && len < 24'h190)
        begin
            @(negedge mclk);
            len++;
        end
        conv = 1'b0;
        repeat (6) @(negedge mclk);
    endtask
    // reset values, then a conversion with the bus deselected
    task automatic t_first_conv();
        logic [23:0] len;
        check("busy", {23'h0, busy}, 24'h0);
        check("asleep", {23'h0, pdn}, 24'h0);
        convert(1'b0, len);
        check("busy length", len, 24'h96);
    endtask
    // every span code; each frame reads back the previous conversion
    task automatic t_codes(input logic mode);
        logic [23:0] len;
        @(negedge mclk);
        lvds = mode;
        repeat (16) @(negedge mclk);
        for (int c = 0; c < 8; c++)
        begin
            oac_host_model_inst.frame(mode, {21'h1FFFFF, 3'(c)});
            check("ch0 word", cap[24:1], exp_word(3'(c) - 3'h1));
            convert(1'b0, len);
        end
    endtask
    // sleep refuses starts; double pulse resets span; pd mid-conversion waits
    task automatic t_power();
        logic [23:0] len;
        oac_host_model_inst.frame(lvds, 24'hFFFFF8);
        repeat (2)
        begin
            @(negedge mclk);
            pd = 1'b1;
            repeat (10) @(negedge mclk);
            check("asleep", {23'h0, pdn}, 24'h1);
            conv = 1'b1;
            repeat (10) @(negedge mclk);
            check("busy asleep", {23'h0, busy}, 24'h0);
            conv = 1'b0;
            pd = 1'b0;
            repeat (10) @(negedge mclk);
        end
        convert(1'b0, len);
        oac_host_model_inst.frame(lvds, 24'hFFFFFF);
        check("span after reset", cap[24:1], exp_word(3'h7));
        convert(1'b1, len);
        check("busy length pd", len, 24'h96);
        check("asleep after", {23'h0, pdn}, 24'h1);
        pd = 1'b0;
        repeat (10) @(negedge mclk);
    endtask
    initial
    begin
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        repeat (8) @(negedge mclk);
        t_first_conv();
        t_codes(1'b0);
        t_codes(1'b1);
        t_power();
        print_verdict();
    end
    // hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            print_verdict();
        end
    end
endmodule
